//--- verif/ssca_master.sv
// bus master model driving scl and sda through open-drain wires
`timescale 1ns/1ps
module ssca_master #(
  parameter int HALF = 200
) (
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // both lines start released, so the pull-ups hold them high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic put(input logic b);
    #(HALF / 2) sda_out = b;
    #(HALF / 2) scl_out = 1'b1;
    #HALF scl_out = 1'b0;
  endtask
  task automatic get(output logic b);
    #(HALF / 2) sda_out = 1'b1;
    #(HALF / 2) scl_out = 1'b1;
    #(HALF / 2) b = sda_in;
    #(HALF / 2) scl_out = 1'b0;
  endtask
  // also serves as repeated start; sda moves well after the scl fall
  task automatic start();
    #(HALF / 2) sda_out = 1'b1;
    #HALF scl_out = 1'b1;
    #HALF sda_out = 1'b0;
    #HALF scl_out = 1'b0;
  endtask
  task automatic stop();
    #(HALF / 2) sda_out = 1'b0;
    #(HALF / 2) scl_out = 1'b1;
    #HALF sda_out = 1'b1;
    #HALF;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      put(d[i]);
    end
    get(v);
    ack = ~v;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      get(v);
      d[i] = v;
    end
    put(~mack);
  endtask
endmodule

//--- verif/test_sideband_config_access_slave.sv
// self-checking bench for the sideband config access slave
`timescale 1ns/1ps
module test_sideband_config_access_slave;
  logic sys_clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic resetn_in = 1'b0;
  logic [2:0] strap = 3'h5;
  logic sw_wr = 1'b0;
  logic [6:0] sw_addr = 7'h00;
  logic [31:0] rd_val = 32'h00000000;
  logic scl_m, sda_m, scl_oe, sda_oe, scl_o, sda_o, cfg_wr, cfg_rd;
  ssca_pkg::ssca_req_t req, wr_req, rd_req;
  int bad_count = 0;
  int n_compared = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  logic [7:0] pec;
  // open-drain wires with pull-ups
  wire scl_w = scl_m & ~(scl_oe & ~scl_o);
  wire sda_w = sda_m & ~(sda_oe & ~sda_o);
  ssca_slave dut (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .link_clk_in(link_clk),
    .scl_in(scl_w),
    .scl_out(scl_o),
    .scl_oe_out(scl_oe),
    .sda_in(sda_w),
    .sda_out(sda_o),
    .sda_oe_out(sda_oe),
    .strap_in(strap),
    .sw_addr_wr_in(sw_wr),
    .sw_addr_in(sw_addr),
    .cfg_wr_out(cfg_wr),
    .cfg_rd_out(cfg_rd),
    .cfg_req_out(req),
    .cfg_rdata_in(rd_val)
  );
  ssca_master m (
    .scl_out(scl_m),
    .sda_out(sda_m),
    .sda_in(sda_w)
  );
  always #12.5 sys_clk_in = ~sys_clk_in;
  always #6 link_clk = ~link_clk;
  // register file side only records requests; masking is its job, not tested here
  always @(posedge sys_clk_in) begin
    if (cfg_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_req <= req;
    end
    if (cfg_rd === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
      rd_req <= req;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    end
    return x;
  endfunction
  task automatic wb(input logic [7:0] d, input logic exp_ack);
    logic a;
    pec = crc(pec, d);
    m.wbyte(d, a);
    check("ack", 32'(a), 32'(exp_ack));
  endtask
  task automatic cmds(input logic [7:0] op, input logic [4:0] port, input logic [9:0] dw, input logic [3:0] be);
    wb(op, 1'b1);
    wb({4'h0, port[4:1]}, 1'b1);
    wb({port[0], 1'b0, be, dw[9:8]}, 1'b1);
    wb(dw[7:0], 1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] op, input logic [4:0] port, input logic [9:0] dw,
                    input logic [3:0] be, input logic [31:0] d, input logic hit, input logic more);
    m.start();
    wb({a, 1'b0}, hit);
    if (hit) begin
      cmds(op, port, dw, be);
      for (int i = 3; i >= 0; i--) begin
        wb(d[i*8 +: 8], 1'b1);
      end
      if (more) begin
        wb(8'hA5, 1'b0);
      end
    end
    m.stop();
    // request follows the stop after a few sync cycles
    repeat (40) @(posedge sys_clk_in);
  endtask
  task automatic t_write();
    int c;
    c = wr_cnt;
    wr(7'h6D, 8'h03, 5'h05, 10'h3C5, 4'hA, 32'h12345678, 1'b1, 1'b1);
    check("wr count", 32'(wr_cnt), 32'(c + 1));
    check("port", 32'(wr_req.port), 32'h5);
    check("dw", 32'(wr_req.dw), 32'h3C5);
    check("be", 32'(wr_req.be), 32'hA);
    check("wdata", wr_req.wdata, 32'h12345678);
    $display("test write done");
  endtask
  task automatic t_pcall(input logic use_pec);
    logic [7:0] d;
    logic [7:0] exp;
    logic [39:0] got;
    int c;
    c = rd_cnt;
    @(negedge sys_clk_in);
    rd_val = use_pec ? 32'hC3A55A3C : 32'h8001FF7E;
    pec = 8'h00;
    m.start();
    wb({7'h6D, 1'b0}, 1'b1);
    wb(8'hCD, 1'b1);
    wb(8'h04, 1'b1);
    cmds(8'h04, 5'h02, 10'h23E, 4'hF);
    m.start();
    wb({7'h6D, 1'b1}, 1'b1);
    for (int i = 0; i < 5; i++) begin
      m.rbyte(i < 4 || use_pec, d);
      pec = crc(pec, d);
      got = {got[31:0], d};
    end
    check("count", 32'(got[39:32]), 32'h4);
    check("rdata", got[31:0], rd_val);
    if (use_pec) begin
      exp = pec;
      m.rbyte(1'b1, d);
      check("pec", 32'(d), 32'(exp));
    end
    m.stop();
    check("sda idle", 32'(sda_w), 32'h1);
    repeat (40) @(posedge sys_clk_in);
    check("rd count", 32'(rd_cnt), 32'(c + 1));
    check("rd port", 32'(rd_req.port), 32'h2);
    check("rd dw", 32'(rd_req.dw), 32'h23E);
    $display("test process call done");
  endtask
  task automatic t_bad();
    int c;
    c = wr_cnt;
    wr(7'h6D, 8'h07, 5'h01, 10'h010, 4'hF, 32'hFFFFFFFF, 1'b1, 1'b0);
    wr(7'h6D, 8'h03, 5'h06, 10'h010, 4'hF, 32'hFFFFFFFF, 1'b1, 1'b0);
    wr(7'h68, 8'h03, 5'h01, 10'h010, 4'hF, 32'hFFFFFFFF, 1'b0, 1'b0);
    check("bad wr", 32'(wr_cnt), 32'(c));
    $display("test invalid done");
  endtask
  task automatic t_addr();
    int c;
    @(negedge sys_clk_in);
    sw_addr = 7'h2A;
    sw_wr = 1'b1;
    @(negedge sys_clk_in);
    sw_wr = 1'b0;
    repeat (20) @(posedge sys_clk_in);
    c = wr_cnt;
    wr(7'h2A, 8'h03, 5'h01, 10'h004, 4'hF, 32'h00000001, 1'b1, 1'b0);
    check("sw wr", 32'(wr_cnt), 32'(c + 1));
    wr(7'h6D, 8'h03, 5'h01, 10'h004, 4'hF, 32'h00000001, 1'b0, 1'b0);
    wr(7'h2A, 8'h03, 5'h00, 10'h0D1, 4'h1, 32'h000000B4, 1'b1, 1'b0);
    wr(7'h5A, 8'h03, 5'h01, 10'h004, 4'hF, 32'h00000002, 1'b1, 1'b0);
    check("scl oe", 32'(scl_oe), 32'h0);
    check("scl out", 32'(scl_o), 32'h0);
    check("sda out", 32'(sda_o), 32'h0);
    $display("test address done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    resetn_in = 1'b1;
    repeat (20) @(posedge sys_clk_in);
    t_write();
    t_pcall(1'b0);
    t_pcall(1'b1);
    t_bad();
    t_addr();
    end_sim();
  end
  initial begin
    #1500000;
    bad_count++;
    end_sim();
  end
endmodule

//--- verilog/ssca_pkg.sv
// constants, types and request carrier for the sideband config access slave
package ssca_pkg;
  localparam logic [3:0] ADDR_HI = 4'hD;
  localparam logic [2:0] ADDR_LO_RST = 3'h0;
  localparam logic [7:0] CMD_PC = 8'hCD;
  localparam logic [7:0] BYTE_CNT = 8'h04;
  localparam logic [2:0] OP_WR = 3'h3;
  localparam logic [2:0] OP_RD = 3'h4;
  localparam logic [4:0] PORT_MAX = 5'h05;
  localparam logic [4:0] PORT_UP = 5'h00;
  localparam logic [9:0] CTRL_DW = 10'h0D1;
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] I2C_LAST = 4'h7;
  localparam logic [3:0] PC_LAST = 4'h5;
  localparam logic [3:0] PC_HDR = 4'h2;
  localparam logic [3:0] I2C_DONE = 4'h8;
  localparam logic [3:0] PC_DONE = 4'h6;
  localparam logic [2:0] TX_LAST = 3'h5;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_IGN} ssca_state_t;
  typedef struct packed {
    logic [4:0] port;
    logic [9:0] dw;
    logic [3:0] be;
    logic [31:0] wdata;
  } ssca_req_t;
endpackage

//--- verilog/ssca_slave.sv
// serial sideband slave giving an outside master access to 32-bit config registers
`timescale 1ns/1ps
// Operation
// - process-call read runs START to STOP, repeated START between write and read parts.
// - write part carries count 4 and four command bytes; reply is count 4, four data.
// - with PEC, device appends PEC after fourth data byte; master acks then stops.
// - slave address is 1101 over the three strap pins, lowest pin in bit 0.
// - software can replace the slave address via upstream register 344h bits 7:1.
// - sideband register access works whatever the upstream link state.
// - START opens, STOP closes; every byte followed by ack or nak from receiver.
// - an invalid command leaves the addressed register unchanged.
// - first write data byte goes to bits 31:24, then bytes 2, 1, 0.
// - device naks every write data byte beyond the fourth.
// - device is slave only; clock and data pins are bidirectional; here scl_oe_out is tied low, so only the data pin is ever driven.
// - port select bits 4:1 from command byte 2 bits 3:0, bit 0 from byte 3 bit 7.
// - byte enables in command byte 3 bits 5:2; only enabled bytes change.
// - dword address 11:10 from byte 3 bits 1:0, 9:2 from byte 4.
module ssca_slave (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [2:0] strap_in,
  input wire logic sw_addr_wr_in,
  input wire logic [6:0] sw_addr_in,
  output logic cfg_wr_out,
  output logic cfg_rd_out,
  output ssca_pkg::ssca_req_t cfg_req_out,
  input wire logic [31:0] cfg_rdata_in
);
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ ssca_pkg::PEC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // local aliases of the package states, since nothing is imported
  localparam ssca_pkg::ssca_state_t S_IDLE = ssca_pkg::S_IDLE;
  localparam ssca_pkg::ssca_state_t S_ADDR = ssca_pkg::S_ADDR;
  localparam ssca_pkg::ssca_state_t S_RX = ssca_pkg::S_RX;
  localparam ssca_pkg::ssca_state_t S_TX = ssca_pkg::S_TX;
  localparam ssca_pkg::ssca_state_t S_IGN = ssca_pkg::S_IGN;

  // ---------------- link domain ----------------
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic [6:0] adr_m_q, adr_s_q, adr_p_q, adr_l_q, adr_l_d;
  logic ackt_m_q, ackt_s_q, ackt_p_q;
  ssca_pkg::ssca_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d, bcnt_q, bcnt_d;
  logic ack_q, ack_d, pc_q, pc_d, bad_q, bad_d, mack_q, mack_d, drv_q, drv_d;
  logic [7:0] sh_q, sh_d, txb_q, txb_d, crc_q, crc_d;
  logic [2:0] txi_q, txi_d;
  logic [7:0] buf_q [8];
  logic [7:0] buf_d [8];
  logic req_tgl_q, req_tgl_d, req_rd_q, req_rd_d, rdy_q, rdy_d;
  logic [31:0] rdat_q, rdat_d;
  logic start_w, stop_w, rise_w, fall_w, wr_ok, rd_ok;
  logic [3:0] lim, idx;
  logic [7:0] txsel;
  ssca_pkg::ssca_req_t req_w;
  // sys-side registers read across the crossing
  logic [6:0] adr_sys_q;
  logic [31:0] rdat_sys_q;
  logic ackt_q;

  assign start_w = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_w = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
  assign rise_w = scl_s_q && !scl_p_q;
  assign fall_w = !scl_s_q && scl_p_q;
  assign req_w.port = {buf_q[1][3:0], buf_q[2][7]};
  assign req_w.dw = {buf_q[2][1:0], buf_q[3]};
  assign req_w.be = buf_q[2][5:2];
  assign req_w.wdata = {buf_q[4], buf_q[5], buf_q[6], buf_q[7]};
  // malformed or short packets never produce a request
  assign wr_ok = !pc_q && bcnt_q == ssca_pkg::I2C_DONE && buf_q[0][2:0] == ssca_pkg::OP_WR
                 && req_w.port <= ssca_pkg::PORT_MAX;
  assign rd_ok = pc_q && !bad_q && bcnt_q == ssca_pkg::PC_DONE && buf_q[0][2:0] == ssca_pkg::OP_RD
                 && req_w.port <= ssca_pkg::PORT_MAX;
  assign lim = pc_q ? ssca_pkg::PC_LAST : ssca_pkg::I2C_LAST;
  assign idx = pc_q ? 4'(bcnt_q - ssca_pkg::PC_HDR) : bcnt_q;

  always_comb begin
    unique case (txi_q)
      3'h0: txsel = ssca_pkg::BYTE_CNT;
      3'h1: txsel = rdat_q[31:24];
      3'h2: txsel = rdat_q[23:16];
      3'h3: txsel = rdat_q[15:8];
      3'h4: txsel = rdat_q[7:0];
      default: txsel = crc_q;
    endcase
  end

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    bcnt_d = bcnt_q;
    ack_d = ack_q;
    pc_d = pc_q;
    bad_d = bad_q;
    mack_d = mack_q;
    drv_d = drv_q;
    sh_d = sh_q;
    txb_d = txb_q;
    crc_d = crc_q;
    txi_d = txi_q;
    buf_d = buf_q;
    req_tgl_d = req_tgl_q;
    req_rd_d = req_rd_q;
    rdy_d = rdy_q;
    rdat_d = rdat_q;
    adr_l_d = (adr_s_q == adr_p_q) ? adr_s_q : adr_l_q;
    if (start_w) begin
      if (wr_ok) begin
        req_tgl_d = !req_tgl_q;
        req_rd_d = 1'b0;
      end else if (rd_ok) begin
        req_tgl_d = !req_tgl_q;
        req_rd_d = 1'b1;
        rdy_d = 1'b0;
      end
      if (st_q == S_IDLE) begin
        crc_d = 8'h00;
      end
      st_d = S_ADDR;
      bit_d = 4'h0;
      ack_d = 1'b0;
      drv_d = 1'b0;
      bcnt_d = 4'h0;
    end else if (stop_w) begin
      if (wr_ok) begin
        req_tgl_d = !req_tgl_q;
        req_rd_d = 1'b0;
      end
      st_d = S_IDLE;
      drv_d = 1'b0;
      bcnt_d = 4'h0;
      rdy_d = 1'b0;
    end else if (rise_w && st_q != S_IDLE) begin
      if (!ack_q) begin
        sh_d = {sh_q[6:0], sda_s_q};
        bit_d = 4'(bit_q + 4'h1);
      end else begin
        mack_d = !sda_s_q;
      end
    end else if (fall_w && st_q != S_IDLE) begin
      if (!ack_q && bit_q == ssca_pkg::BIT_ACK) begin
        ack_d = 1'b1;
        drv_d = 1'b0;
        crc_d = crc8(crc_q, sh_q);
        unique case (st_q)
          S_ADDR: begin
            if (sh_q[7:1] != adr_l_q) begin
              st_d = S_IGN;
            end else if (!sh_q[0]) begin
              st_d = S_RX;
              drv_d = 1'b1;
              pc_d = 1'b0;
              bad_d = 1'b0;
            end else if (rdy_q) begin
              st_d = S_TX;
              drv_d = 1'b1;
              txi_d = 3'h0;
              mack_d = 1'b1;
            end else begin
              st_d = S_IGN;
            end
          end
          S_RX: begin
            drv_d = bcnt_q <= lim;
            if (bcnt_q <= lim) begin
              bcnt_d = 4'(bcnt_q + 4'h1);
            end
            if (bcnt_q == 4'h0 && sh_q == ssca_pkg::CMD_PC) begin
              pc_d = 1'b1;
            end else if (pc_q && bcnt_q == 4'h1) begin
              bad_d = sh_q != ssca_pkg::BYTE_CNT;
            end else if (bcnt_q <= lim) begin
              buf_d[idx[2:0]] = sh_q;
            end
          end
          default: begin
          end
        endcase
      end else if (ack_q) begin
        ack_d = 1'b0;
        bit_d = 4'h0;
        drv_d = 1'b0;
        if (st_q == S_TX) begin
          if (mack_q && txi_q <= ssca_pkg::TX_LAST) begin
            txb_d = txsel;
            drv_d = !txsel[7];
            txi_d = 3'(txi_q + 3'h1);
          end else begin
            st_d = S_IGN;
          end
        end
      end else if (st_q == S_TX) begin
        drv_d = !txb_q[3'(3'h7 - bit_q[2:0])];
      end
    end
    // read data is stable in the sys register once the ack toggle is seen
    if (ackt_s_q != ackt_p_q) begin
      rdat_d = rdat_sys_q;
      rdy_d = req_rd_q;
    end
  end

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3F;
      {adr_m_q, adr_s_q, adr_p_q} <= {3{ssca_pkg::ADDR_HI, ssca_pkg::ADDR_LO_RST}};
      adr_l_q <= {ssca_pkg::ADDR_HI, ssca_pkg::ADDR_LO_RST};
      {ackt_m_q, ackt_s_q, ackt_p_q} <= 3'h0;
      st_q <= S_IDLE;
      {bit_q, bcnt_q} <= 8'h00;
      {ack_q, pc_q, bad_q, mack_q, drv_q} <= 5'h00;
      {sh_q, txb_q, crc_q} <= 24'h000000;
      txi_q <= 3'h0;
      for (int i = 0; i < 8; i++) begin
        buf_q[i] <= 8'h00;
      end
      {req_tgl_q, req_rd_q, rdy_q} <= 3'h0;
      rdat_q <= 32'h00000000;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
      {adr_m_q, adr_s_q, adr_p_q} <= {adr_sys_q, adr_m_q, adr_s_q};
      adr_l_q <= adr_l_d;
      {ackt_m_q, ackt_s_q, ackt_p_q} <= {ackt_q, ackt_m_q, ackt_s_q};
      st_q <= st_d;
      {bit_q, bcnt_q} <= {bit_d, bcnt_d};
      {ack_q, pc_q, bad_q, mack_q, drv_q} <= {ack_d, pc_d, bad_d, mack_d, drv_d};
      {sh_q, txb_q, crc_q} <= {sh_d, txb_d, crc_d};
      txi_q <= txi_d;
      buf_q <= buf_d;
      {req_tgl_q, req_rd_q, rdy_q} <= {req_tgl_d, req_rd_d, rdy_d};
      rdat_q <= rdat_d;
    end
  end

  // open drain: only ever pull low; no clock stretching
  assign sda_out = 1'b0;
  assign sda_oe_out = drv_q;
  assign scl_out = 1'b0;
  assign scl_oe_out = 1'b0;

  // ---------------- system domain ----------------
  // no input from the upstream link state gates any access here
  logic [2:0] strap_m_q, strap_s_q;
  logic req_m_q, req_s_q, req_p_q, ovr_q, ovr_d;
  logic [6:0] sw_q, sw_d, adr_sys_d;
  logic cfg_wr_d, cfg_rd_d, ackt_d;
  logic [31:0] rdat_sys_d;
  ssca_pkg::ssca_req_t cfg_req_q, cfg_req_d;

  always_comb begin
    cfg_wr_d = 1'b0;
    cfg_rd_d = 1'b0;
    cfg_req_d = cfg_req_q;
    ackt_d = ackt_q;
    rdat_sys_d = rdat_sys_q;
    ovr_d = ovr_q;
    sw_d = sw_q;
    if (req_s_q != req_p_q) begin
      cfg_req_d = req_w;
      cfg_wr_d = !req_rd_q;
      cfg_rd_d = req_rd_q;
    end
    if (cfg_rd_out) begin
      rdat_sys_d = cfg_rdata_in;
      ackt_d = !ackt_q;
    end
    if (sw_addr_wr_in) begin
      ovr_d = 1'b1;
      sw_d = sw_addr_in;
    end else if (cfg_wr_out && cfg_req_q.port == ssca_pkg::PORT_UP && cfg_req_q.dw == ssca_pkg::CTRL_DW
                 && cfg_req_q.be[0]) begin
      ovr_d = 1'b1;
      sw_d = cfg_req_q.wdata[7:1];
    end
    adr_sys_d = ovr_q ? sw_q : {ssca_pkg::ADDR_HI, strap_s_q};
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {strap_m_q, strap_s_q} <= 6'h00;
      {req_m_q, req_s_q, req_p_q} <= 3'h0;
      {ovr_q, cfg_wr_out, cfg_rd_out, ackt_q} <= 4'h0;
      sw_q <= 7'h00;
      adr_sys_q <= {ssca_pkg::ADDR_HI, ssca_pkg::ADDR_LO_RST};
      rdat_sys_q <= 32'h00000000;
      cfg_req_q <= '0;
    end else begin
      {strap_m_q, strap_s_q} <= {strap_in, strap_m_q};
      {req_m_q, req_s_q, req_p_q} <= {req_tgl_q, req_m_q, req_s_q};
      {ovr_q, cfg_wr_out, cfg_rd_out, ackt_q} <= {ovr_d, cfg_wr_d, cfg_rd_d, ackt_d};
      sw_q <= sw_d;
      adr_sys_q <= adr_sys_d;
      rdat_sys_q <= rdat_sys_d;
      cfg_req_q <= cfg_req_d;
    end
  end
  // enables travel out so the register file touches only enabled bytes
  assign cfg_req_out = cfg_req_q;

  // ---------------- assertions ----------------
  sequence s_byte_end;
    fall_w && !ack_q && bit_q == ssca_pkg::BIT_ACK && !start_w && !stop_w;
  endsequence
  property p_nak_extra;
    @(posedge link_clk_in) disable iff (!resetn_in)
    s_byte_end ##0 (st_q == S_RX && !pc_q && bcnt_q > ssca_pkg::I2C_LAST) |=> !drv_q [*2];
  endproperty
  a_nak_extra: assert property (p_nak_extra) else $error("extra data byte acked");
  property p_addr_miss;
    @(posedge link_clk_in) disable iff (!resetn_in)
    s_byte_end ##0 (st_q == S_ADDR && sh_q[7:1] != adr_l_q) |=> st_q == S_IGN && !drv_q;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");
  property p_wr_valid;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    cfg_wr_out |-> cfg_req_out.port <= ssca_pkg::PORT_MAX;
  endproperty
  a_wr_valid: assert property (p_wr_valid) else $error("write to invalid port");
  property p_rd_at_sr;
    @(posedge link_clk_in) disable iff (!resetn_in)
    $changed(req_tgl_q) && req_rd_q |-> $past(start_w) && $past(st_q) != S_IDLE;
  endproperty
  a_rd_at_sr: assert property (p_rd_at_sr) else $error("read not latched at repeated start");
  property p_tx_count;
    @(posedge link_clk_in) disable iff (!resetn_in)
    st_q == S_TX && txi_q == 3'h1 |-> txb_q == ssca_pkg::BYTE_CNT;
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("reply count not 4");
  property p_sw_addr;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    sw_addr_wr_in |=> ##1 adr_sys_q == $past(sw_addr_in, 2);
  endproperty
  a_sw_addr: assert property (p_sw_addr) else $error("address override lost");
  property p_pulse;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (cfg_wr_out || cfg_rd_out) |=> !cfg_wr_out && !cfg_rd_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("access pulse too long");
  property p_release;
    @(posedge link_clk_in) disable iff (!resetn_in)
    stop_w |=> !sda_oe_out && !scl_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("bus held after stop");
endmodule
